// file: sci_defines.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * asynchronous serial transceiver. Assumes a 250 MHz system clock.
 */
`ifndef SCI_DEFINES_VH
`define SCI_DEFINES_VH

// system clock and fastest line rate
`define SCI_CLK_HZ 250000000
`define SCI_BAUD_MAX 500000
// least divisor period in clocks for one sixteenth of a bit, rounded up
`define SCI_MIN_DIV ((`SCI_CLK_HZ + 16 * `SCI_BAUD_MAX - 1) / (16 * `SCI_BAUD_MAX))
`define SCI_DIV_FLOOR 16'h001F
`define SCI_DIV_RST 16'h001F

// register byte offsets
`define SCI_A_STATUS 8'h00
`define SCI_A_DATA 8'h04
`define SCI_A_CTRL1 8'h08
`define SCI_A_CTRL2 8'h0C
`define SCI_A_TXDIV 8'h10
`define SCI_A_RXDIV 8'h14

// register select codes
`define SCI_S_STATUS 3'h0
`define SCI_S_DATA 3'h1
`define SCI_S_CTRL1 3'h2
`define SCI_S_CTRL2 3'h3
`define SCI_S_TXDIV 3'h4
`define SCI_S_RXDIV 3'h5
`define SCI_S_NONE 3'h7

// status bits
`define SCI_B_TX_BUF_EMPTY_FLAG 7
`define SCI_B_TC 6
`define SCI_B_RX_BUF_FULL_FLAG 5
`define SCI_B_OVR 3
`define SCI_B_NF 2
`define SCI_B_FE 1
// control 1 bits
`define SCI_B_WORD9 0
`define SCI_B_T9 1
`define SCI_B_R9 2
// control 2 bits
`define SCI_B_SBK 0
`define SCI_B_RXEN 1
`define SCI_B_TXEN 2
`define SCI_B_RIE 4
`define SCI_B_TX_COMPLETE_IRQ_EN 6
`define SCI_B_TIE 7

// frame lengths in bit times, start and stop included
`define SCI_LEN8 4'hA
`define SCI_LEN9 4'hB
`define SCI_SUB_LAST 4'hF

// bus answers
`define SCI_RESP_OK 2'h0
`define SCI_RESP_ERR 2'h2

`endif

// file: sci_node.sv
/* far-end serial node: sends frames on the receive line, captures frames from the pin.
   assumes bits of BIT clocks and a line that idles high. */
`timescale 1ns/10ps
module sci_node #(parameter int BIT = 512) (
	input wire logic mclk_i,
	input wire logic tx_i,
	input wire logic tx_oe_i,
	output logic line_o
);
	logic [31:0] cap [0:15];
	int ncap = 0;
	bit w9 = 1'b0;
	time t_start;
	initial line_o = 1'b1;
	// capture at mid-bit: data LSB first in bits 8:0, stop level in bit 9
	initial begin : grab
		logic [9:0] f;
		int i;
		forever begin
			@(negedge tx_i);
			if (tx_oe_i) begin
				t_start = $time;
				f = 10'h000;
				repeat (BIT / 2) @(posedge mclk_i);
				for (i = 0; i < 8 + w9; i++) begin
					repeat (BIT) @(posedge mclk_i);
					f[i] = tx_i;
				end
				repeat (BIT) @(posedge mclk_i);
				f[9] = tx_i;
				if (ncap < 16) cap[ncap] = {22'h000000, f};
				ncap++;
			end
		end
	end
	// one frame: start low, bits LSB first, chosen stop level, then idle high
	task send(input logic [8:0] d, input int nb, input logic stopv);
		int i;
		line_o <= 1'b0;
		repeat (BIT) @(posedge mclk_i);
		for (i = 0; i < nb; i++) begin
			line_o <= d[i];
			repeat (BIT) @(posedge mclk_i);
		end
		line_o <= stopv;
		repeat (BIT) @(posedge mclk_i);
		line_o <= 1'b1;
		repeat (16) @(posedge mclk_i);
	endtask
endmodule // sci_node

// file: sci_rx.v
/*
 * Receive shifter: start search, sixteen-fold oversampling, majority vote.
 * Assumes a one-cycle tick at sixteen times the bit rate, input synchronous.
 */
`timescale 1ns/10ps
`include "sci_defines.vh"

module sci_rx (
	input wire mclk_i,
	input wire rst_i,
	input wire en_i,
	input wire tick_i,
	input wire word9_i,
	input wire rx_i,
	output reg done_o,
	output reg [8:0] data_o,
	output reg fe_o,
	output reg nf_o
);

reg act;
reg [3:0] sub;
reg [3:0] bitn;
reg s7;
reg s8;
reg [8:0] sh;
reg noisy;
wire vote = (s7 & s8) | (s7 & rx_i) | (s8 & rx_i);
wire differ = (s7 != s8) || (s8 != rx_i);
wire [3:0] last = word9_i ? `SCI_LEN9 - 4'h1 : `SCI_LEN8 - 4'h1;

// start search, centre sampling and framing
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		act <= 1'b0;
		sub <= 4'h0;
		bitn <= 4'h0;
		s7 <= 1'b1;
		s8 <= 1'b1;
		sh <= 9'h000;
		noisy <= 1'b0;
		done_o <= 1'b0;
		data_o <= 9'h000;
		fe_o <= 1'b0;
		nf_o <= 1'b0;
	end else begin
		done_o <= 1'b0;
		if (!en_i) begin
			act <= 1'b0;
		end else if (tick_i) begin
			if (!act) begin
				if (!rx_i) begin
					act <= 1'b1;
					sub <= 4'h1;
					bitn <= 4'h0;
					noisy <= 1'b0;
				end
			end else begin
				sub <= sub + 4'h1;
				if (sub == 4'h7)
					s7 <= rx_i;
				if (sub == 4'h8)
					s8 <= rx_i;
				if (sub == 4'h9) begin
					if (differ)
						noisy <= 1'b1;
					if (bitn == 4'h0 && vote) begin
						act <= 1'b0;
					end else if (bitn == last) begin
						act <= 1'b0;
						done_o <= 1'b1;
						data_o <= word9_i ? sh : {1'b0, sh[8:1]};
						fe_o <= !vote;
						nf_o <= noisy || differ;
					end else if (bitn != 4'h0) begin
						sh <= {vote, sh[8:1]};
					end
				end
				if (sub == `SCI_SUB_LAST)
					bitn <= bitn + 4'h1;
			end
		end
	end
end

endmodule // sci_rx

// file: sci_top.v
/*
 * Full-duplex asynchronous serial transceiver with an AXI4-Lite register
 * slave. Assumes synchronous serial input and one 250 MHz clock.
 */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
// Summary of operation
// - enabled transmitter with nothing to send holds the line high.
// - disabled transmitter releases the pin to the port.
// - start bit is driven low, stop bit high.
// - idle character is 10 or 11 bit times of high level.
// - break is a run of low bits then one high bit.
// - breaks repeat while send break is set, then one high bit follows.
// - ninth transmitted bit comes from the transmit ninth bit control.
// - data written during a frame waits in the holding buffer.
// - data written while idle starts at once and sets buffer empty.
// - buffer empty clears on status access then data write.
// - buffer empty with its enable and unmasked CPU raises interrupt.
// - after the stop bit, complete flag sets and may interrupt.
// - complete flag clears by the same access sequence.
// - enabling the transmitter first sends an idle preamble.
// - re-enabling mid-frame sends a preamble after the current word.
// - received ninth bit goes to the receive ninth bit status.
// - receive enable starts the search for a start bit.
// - finished character moves to holding buffer, sets full, may interrupt.
// - framing, noise and overrun flags set when detected.
// - receiver oversamples the input to reject noise.
// - transmit and receive rates are set apart, up to 500K baud.
// - full flag clears on status access then data read.
// - character during full sets overrun and keeps the buffer.
// - missing stop bit or break sets framing error, data still moves.
`timescale 1ns/10ps
`include "sci_defines.vh"

module sci_top (
	input wire mclk_i,
	input wire rst_i,
	input wire [7:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [7:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire serial_rx_in_i,
	input wire [1:0] cpu_cond_reg_mask_i,
	output wire tx_o,
	output wire tx_oe_o,
	output reg irq_o
);

// register select from a byte address
function [2:0] sci_sel;
	input [7:0] addr;
	begin
		case (addr)
			`SCI_A_STATUS: sci_sel = `SCI_S_STATUS;
			`SCI_A_DATA: sci_sel = `SCI_S_DATA;
			`SCI_A_CTRL1: sci_sel = `SCI_S_CTRL1;
			`SCI_A_CTRL2: sci_sel = `SCI_S_CTRL2;
			`SCI_A_TXDIV: sci_sel = `SCI_S_TXDIV;
			`SCI_A_RXDIV: sci_sel = `SCI_S_RXDIV;
			default: sci_sel = `SCI_S_NONE;
		endcase
	end
endfunction

// divisor written by software, kept at or above the fastest legal rate
function [15:0] sci_clamp;
	input [15:0] v;
	begin
		if (v < `SCI_DIV_FLOOR)
			sci_clamp = `SCI_DIV_FLOOR;
		else
			sci_clamp = v;
	end
endfunction

// bus slave state
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

// control registers
reg word9;
reg tx_ninth_bit;
reg send_break;
reg tx_enable;
reg rx_enable;
reg rx_full_irq_en;
reg tx_complete_irq_en;
reg tx_empty_irq_en;
reg [15:0] tx_div;
reg [15:0] rx_div;

// baud ticks
reg [15:0] tx_cnt;
reg [15:0] rx_cnt;
reg tx_tick;
reg rx_tick;

// transmit side state
reg tx_hold_valid;
reg [7:0] tx_holding_buf;
reg tx_buf_empty_flag;
reg tx_complete_flag;
reg tx_armed;

// receive side state
reg [8:0] rx_holding_buf;
reg rx_buf_full_flag;
reg overrun_flag;
reg noise_flag;
reg frame_err_flag;
reg rx_armed;

wire tx_take;
wire tx_done;
wire rx_done;
wire [8:0] rx_data;
wire rx_fe;
wire rx_nf;

// decoded bus events
wire wr_go = aw_held && w_held && !s_axi_bvalid_o;
wire [2:0] wsel = sci_sel(aw_addr);
wire rd_go = s_axi_arvalid_i && s_axi_arready_o;
wire [2:0] rsel = sci_sel(s_axi_araddr_i);
wire wr_lo = wr_go && w_strb[0];
wire wr_hi = wr_go && w_strb[1];
wire stat_acc = (rd_go && rsel == `SCI_S_STATUS) || (wr_go && wsel == `SCI_S_STATUS);
wire wr_dat = wr_lo && wsel == `SCI_S_DATA;
wire rd_dat = rd_go && rsel == `SCI_S_DATA;
wire tx_clr = wr_dat && tx_armed;
wire rx_clr = rd_dat && rx_armed;

// status word as software reads it
wire [7:0] status_val = {tx_buf_empty_flag, tx_complete_flag, rx_buf_full_flag, 1'b0,
	overrun_flag, noise_flag, frame_err_flag, 1'b0};
wire [7:0] ctrl1_val = {5'h00, rx_holding_buf[8], tx_ninth_bit, word9};
wire [7:0] ctrl2_val = {tx_empty_irq_en, tx_complete_irq_en, 1'b0, rx_full_irq_en, 1'b0,
	tx_enable, rx_enable, send_break};

// write address and data channels, taken in either order
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_awready_o <= 1'b1;
		s_axi_wready_o <= 1'b1;
		s_axi_bvalid_o <= 1'b0;
		s_axi_bresp_o <= `SCI_RESP_OK;
	end else begin
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
			s_axi_awready_o <= 1'b0;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
			s_axi_wready_o <= 1'b0;
		end
		if (wr_go) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= (wsel == `SCI_S_NONE) ? `SCI_RESP_ERR : `SCI_RESP_OK;
		end
		if (s_axi_bvalid_o && s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
		end
	end
end

// read channel, answered one cycle after the address is taken
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		s_axi_arready_o <= 1'b1;
		s_axi_rvalid_o <= 1'b0;
		s_axi_rdata_o <= 32'h00000000;
		s_axi_rresp_o <= `SCI_RESP_OK;
	end else begin
		if (rd_go) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `SCI_RESP_OK;
			case (rsel)
				`SCI_S_STATUS: s_axi_rdata_o <= {24'h000000, status_val};
				`SCI_S_DATA: s_axi_rdata_o <= {24'h000000, rx_holding_buf[7:0]};
				`SCI_S_CTRL1: s_axi_rdata_o <= {24'h000000, ctrl1_val};
				`SCI_S_CTRL2: s_axi_rdata_o <= {24'h000000, ctrl2_val};
				`SCI_S_TXDIV: s_axi_rdata_o <= {16'h0000, tx_div};
				`SCI_S_RXDIV: s_axi_rdata_o <= {16'h0000, rx_div};
				default: begin
					s_axi_rdata_o <= 32'h00000000;
					s_axi_rresp_o <= `SCI_RESP_ERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
end

// control register writes
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		word9 <= 1'b0;
		tx_ninth_bit <= 1'b0;
		send_break <= 1'b0;
		tx_enable <= 1'b0;
		rx_enable <= 1'b0;
		rx_full_irq_en <= 1'b0;
		tx_complete_irq_en <= 1'b0;
		tx_empty_irq_en <= 1'b0;
		tx_div <= `SCI_DIV_RST;
		rx_div <= `SCI_DIV_RST;
	end else begin
		if (wr_lo && wsel == `SCI_S_CTRL1) begin
			word9 <= w_data[`SCI_B_WORD9];
			tx_ninth_bit <= w_data[`SCI_B_T9];
		end
		if (wr_lo && wsel == `SCI_S_CTRL2) begin
			send_break <= w_data[`SCI_B_SBK];
			rx_enable <= w_data[`SCI_B_RXEN];
			tx_enable <= w_data[`SCI_B_TXEN];
			rx_full_irq_en <= w_data[`SCI_B_RIE];
			tx_complete_irq_en <= w_data[`SCI_B_TX_COMPLETE_IRQ_EN];
			tx_empty_irq_en <= w_data[`SCI_B_TIE];
		end
		// both bytes of a divisor are written together
		if (wr_lo && wr_hi && wsel == `SCI_S_TXDIV)
			tx_div <= sci_clamp(w_data[15:0]);
		if (wr_lo && wr_hi && wsel == `SCI_S_RXDIV)
			rx_div <= sci_clamp(w_data[15:0]);
	end
end

// separate sixteen-times bit rate tick generators
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		tx_cnt <= 16'h0000;
		rx_cnt <= 16'h0000;
		tx_tick <= 1'b0;
		rx_tick <= 1'b0;
	end else begin
		tx_tick <= 1'b0;
		rx_tick <= 1'b0;
		if (tx_cnt >= tx_div) begin
			tx_cnt <= 16'h0000;
			tx_tick <= 1'b1;
		end else begin
			tx_cnt <= tx_cnt + 16'h0001;
		end
		if (!rx_enable || rx_cnt >= rx_div) begin
			rx_cnt <= 16'h0000;
			rx_tick <= rx_enable;
		end else begin
			rx_cnt <= rx_cnt + 16'h0001;
		end
	end
end

// transmit holding buffer and its flags
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		tx_hold_valid <= 1'b0;
		tx_holding_buf <= 8'h00;
		tx_buf_empty_flag <= 1'b1;
		tx_complete_flag <= 1'b1;
		tx_armed <= 1'b0;
	end else begin
		if (wr_dat) begin
			tx_holding_buf <= w_data[7:0];
			tx_hold_valid <= 1'b1;
		end else if (tx_take || !tx_enable) begin
			tx_hold_valid <= 1'b0;
		end
		if (tx_take)
			tx_buf_empty_flag <= 1'b1;
		else if (tx_clr)
			tx_buf_empty_flag <= 1'b0;
		if (tx_done)
			tx_complete_flag <= 1'b1;
		else if (tx_clr)
			tx_complete_flag <= 1'b0;
		if (stat_acc)
			tx_armed <= 1'b1;
		else if (wr_dat)
			tx_armed <= 1'b0;
	end
end

// receive holding buffer and its flags
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		rx_holding_buf <= 9'h000;
		rx_buf_full_flag <= 1'b0;
		overrun_flag <= 1'b0;
		noise_flag <= 1'b0;
		frame_err_flag <= 1'b0;
		rx_armed <= 1'b0;
	end else begin
		if (rx_done && rx_buf_full_flag) begin
			overrun_flag <= 1'b1;
		end else if (rx_done) begin
			rx_holding_buf <= rx_data;
			rx_buf_full_flag <= 1'b1;
			noise_flag <= rx_nf;
			frame_err_flag <= rx_fe;
		end else if (rx_clr) begin
			rx_buf_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
			noise_flag <= 1'b0;
			frame_err_flag <= 1'b0;
		end
		if (stat_acc)
			rx_armed <= 1'b1;
		else if (rd_dat)
			rx_armed <= 1'b0;
	end
end

// interrupt request, gated by the CPU mask bits
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		irq_o <= 1'b0;
	end else begin
		irq_o <= (cpu_cond_reg_mask_i == 2'b00) &&
			((tx_buf_empty_flag && tx_empty_irq_en) ||
			(tx_complete_flag && tx_complete_irq_en) ||
			((rx_buf_full_flag || overrun_flag) && rx_full_irq_en));
	end
end

sci_tx u_tx (
	.mclk_i(mclk_i),
	.rst_i(rst_i),
	.en_i(tx_enable),
	.tick_i(tx_tick),
	.word9_i(word9),
	.brk_i(send_break),
	.load_i(tx_hold_valid),
	.data_i({tx_ninth_bit & word9, tx_holding_buf}),
	.take_o(tx_take),
	.done_o(tx_done),
	.tx_o(tx_o),
	.tx_oe_o(tx_oe_o)
);

sci_rx u_rx (
	.mclk_i(mclk_i),
	.rst_i(rst_i),
	.en_i(rx_enable),
	.tick_i(rx_tick),
	.word9_i(word9),
	.rx_i(serial_rx_in_i),
	.done_o(rx_done),
	.data_o(rx_data),
	.fe_o(rx_fe),
	.nf_o(rx_nf)
);

endmodule // sci_top

// file: sci_top_properties.sv
/* port checker of sci_top: reset state, bus answers, serial timing.
   assumes divisors at or above the floor, so a bit lasts at least 512 clocks. */
`timescale 1ns/10ps
module sci_chk (
	input wire mclk_i,
	input wire rst_i,
	input wire [7:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire [1:0] s_axi_bresp_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [7:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire [31:0] s_axi_rdata_o,
	input wire [1:0] s_axi_rresp_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire [1:0] cpu_cond_reg_mask_i,
	input wire tx_o,
	input wire tx_oe_o,
	input wire irq_o
);
	reg tx_q;
	reg [15:0] run;
	wire aw_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	wire ar_hs = s_axi_arvalid_i && s_axi_arready_o;
	// clocks spent at the present serial level, saturating
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_q <= 1'b1;
			run <= 16'h0000;
		end else begin
			tx_q <= tx_o;
			run <= (tx_o != tx_q) ? 16'h0000 : run + {15'h0000, ~&run};
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	reset_state_a: assert property ($fell(rst_i) |-> s_axi_awready_o && s_axi_arready_o && !s_axi_bvalid_o
		&& !irq_o && !tx_oe_o) else $error("bad state after reset");
	write_ans_a: assert property (aw_hs |-> ##[1:2] s_axi_bvalid_o) else $error("no write response");
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	bad_write_a: assert property (aw_hs && s_axi_awaddr_i == 8'hFC |-> ##[1:2] s_axi_bvalid_o && s_axi_bresp_o == 2'h2)
		else $error("unmapped write not refused");
	read_ans_a: assert property (ar_hs |=> s_axi_rvalid_o) else $error("no read response");
	rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped");
	bad_read_a: assert property (ar_hs && s_axi_araddr_i == 8'hFC |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	preamble_high_a: assert property ($rose(tx_oe_o) |-> tx_o [*8]) else $error("enable not idle high");
	bit_len_a: assert property (tx_oe_o && tx_o != tx_q |-> run >= 16'h01F4) else $error("serial bit too short");
	irq_mask_a: assert property (|cpu_cond_reg_mask_i |=> !irq_o) else $error("masked interrupt raised");
	cover property (tx_oe_o && $fell(tx_o));
	cover property (irq_o);
	cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
endmodule // sci_chk
bind sci_top sci_chk chk (.mclk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .cpu_cond_reg_mask_i,
	.tx_o, .tx_oe_o, .irq_o);

// file: sci_top_tb.sv
/* self-checking bench of sci_top: bus tasks, far-end node, one task a scenario.
   assumes reset divisors, so one bit lasts 512 clocks. */
`timescale 1ns/10ps
`include "sci_defines.vh"
module sci_top_tb;
	localparam int BIT = 512;
	logic mclk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, rx_line, tx, tx_oe, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdat;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp, mask;
	int errors = 0, checked = 0, cyc = 0, n0;
	time t0;
	sci_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .serial_rx_in_i(rx_line),
		.cpu_cond_reg_mask_i(mask), .tx_o(tx), .tx_oe_o(tx_oe), .irq_o(irq));
	sci_node #(.BIT(BIT)) node (.mclk_i(mclk_i), .tx_i(tx), .tx_oe_i(tx_oe), .line_o(rx_line));
	// 250 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// hang guard
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 99000) begin
			errors++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// bus write: address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge mclk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge mclk_i);
	endtask
	// bus read into rdat and rsp
	task rd(input logic [7:0] a);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge mclk_i);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rdat = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge mclk_i);
	endtask
	task wait_cap(input int n);
		int k;
		for (k = 0; k < 40000 && node.ncap < n; k++) @(posedge mclk_i);
		chk(node.ncap, n);
	endtask
	task t_reset();
		rd(`SCI_A_STATUS);
		chk(rdat, 32'hC0);
		rd(8'hFC);
		chk({rsp, rdat[29:0]}, 32'h80000000);
		wr(8'hFC, 32'hFF);
		chk({30'h0, rsp}, 32'h2);
		rd(`SCI_A_CTRL2);
		chk(rdat, 32'h0);
	endtask
	task t_tx8();
		wr(`SCI_A_CTRL2, 32'h04);
		repeat (12 * BIT) @(posedge mclk_i);
		chk({30'h0, tx_oe, tx}, 32'h3);
		rd(`SCI_A_STATUS);
		n0 = node.ncap;
		wr(`SCI_A_DATA, 32'hA5);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'hC0, 32'h80);
		wr(`SCI_A_DATA, 32'h3C);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'hC0, 32'h0);
		wait_cap(n0 + 2);
		chk(node.cap[n0], 32'h2A5);
		chk(node.cap[n0 + 1], 32'h23C);
		repeat (BIT) @(posedge mclk_i);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'hC0, 32'hC0);
	endtask
	task t_tx9();
		node.w9 = 1'b1;
		wr(`SCI_A_CTRL1, 32'h03);
		wr(`SCI_A_CTRL2, 32'h00);
		wr(`SCI_A_CTRL2, 32'h04);
		t0 = $time;
		rd(`SCI_A_STATUS);
		n0 = node.ncap;
		wr(`SCI_A_DATA, 32'h5A);
		wait_cap(n0 + 1);
		chk(node.cap[n0], 32'h35A);
		chk({31'h0, node.t_start - t0 >= (11 * BIT - 64) * 4}, 32'h1);
		repeat (BIT) @(posedge mclk_i);
		node.w9 = 1'b0;
	endtask
	task t_brk();
		wr(`SCI_A_CTRL1, 32'h00);
		n0 = node.ncap;
		wr(`SCI_A_CTRL2, 32'h05);
		repeat (25 * BIT) @(posedge mclk_i);
		wr(`SCI_A_CTRL2, 32'h04);
		repeat (15 * BIT) @(posedge mclk_i);
		chk(node.cap[n0], 32'h0);
		n0 = node.ncap;
		rd(`SCI_A_STATUS);
		wr(`SCI_A_DATA, 32'h81);
		wait_cap(n0 + 1);
		chk(node.cap[n0], 32'h281);
		// let the frame in flight finish before the transmitter is disabled
		repeat (BIT) @(posedge mclk_i);
	endtask
	task t_rx();
		mask <= 2'h3;
		wr(`SCI_A_CTRL2, 32'h12);
		chk({31'h0, tx_oe}, 32'h0);
		node.send(9'h096, 8, 1'b1);
		repeat (64) @(posedge mclk_i);
		chk({31'h0, irq}, 32'h0);
		mask <= 2'h0;
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq}, 32'h1);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'h2E, 32'h20);
		rd(`SCI_A_DATA);
		chk(rdat, 32'h96);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'h20, 32'h0);
		node.send(9'h011, 8, 1'b1);
		node.send(9'h022, 8, 1'b1);
		repeat (64) @(posedge mclk_i);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'h28, 32'h28);
		rd(`SCI_A_DATA);
		chk(rdat, 32'h11);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'h2E, 32'h0);
		wr(`SCI_A_CTRL1, 32'h01);
		node.send(9'h1C3, 9, 1'b1);
		repeat (64) @(posedge mclk_i);
		rd(`SCI_A_CTRL1);
		chk(rdat & 32'h04, 32'h04);
		rd(`SCI_A_STATUS);
		rd(`SCI_A_DATA);
		chk(rdat, 32'hC3);
		wr(`SCI_A_CTRL1, 32'h00);
		node.send(9'h033, 8, 1'b0);
		repeat (64) @(posedge mclk_i);
		rd(`SCI_A_STATUS);
		chk(rdat & 32'h22, 32'h22);
		rd(`SCI_A_DATA);
		chk(rdat, 32'h33);
		wr(`SCI_A_CTRL2, 32'h80);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq}, 32'h1);
	endtask
	// reset, then the scenarios in turn
	initial begin
		rst_i = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		mask = 2'h0;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset();
		t_tx8();
		t_tx9();
		t_brk();
		t_rx();
		end_of_test();
	end
endmodule // sci_top_tb

// file: sci_tx.v
/*
 * Transmit shifter: idle preamble, break and data frames, LSB first.
 * Assumes a one-cycle tick at sixteen times the bit rate.
 */
`timescale 1ns/10ps
`include "sci_defines.vh"

module sci_tx (
	input wire mclk_i,
	input wire rst_i,
	input wire en_i,
	input wire tick_i,
	input wire word9_i,
	input wire brk_i,
	input wire load_i,
	input wire [8:0] data_i,
	output reg take_o,
	output reg done_o,
	output reg tx_o,
	output reg tx_oe_o
);

reg [11:0] sh;
reg [3:0] cnt;
reg [3:0] sub;
reg en_d;
reg pre;
reg brk_tail;
reg is_char;
// a loaded frame waits for the next tick before the line follows it, so every bit is whole
reg lead;
wire rise = en_i && !en_d;
wire [3:0] nbits = word9_i ? `SCI_LEN9 : `SCI_LEN8;
// stop bit and filler ones above the data, start bit at bit 0
wire [11:0] frame = word9_i ? {2'b11, data_i, 1'b0} : {3'b111, data_i[7:0], 1'b0};

// frame sequencing, one bit every sixteen ticks
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		sh <= 12'hFFF;
		cnt <= 4'h0;
		sub <= 4'h0;
		en_d <= 1'b0;
		pre <= 1'b0;
		brk_tail <= 1'b0;
		is_char <= 1'b0;
		lead <= 1'b0;
		take_o <= 1'b0;
		done_o <= 1'b0;
		tx_o <= 1'b1;
		tx_oe_o <= 1'b0;
	end else begin
		take_o <= 1'b0;
		done_o <= 1'b0;
		en_d <= en_i;
		if (cnt == 4'h0) begin
			sub <= 4'h0;
			is_char <= 1'b0;
			lead <= 1'b1;
			// a fresh enable sends its preamble before any break or data
			if ((pre || rise) && en_i) begin
				sh <= 12'hFFF;
				cnt <= nbits;
				pre <= 1'b0;
			end else if (brk_i && en_i) begin
				sh <= 12'h000;
				cnt <= nbits;
				brk_tail <= 1'b1;
			end else if (brk_tail) begin
				sh <= 12'hFFF;
				cnt <= 4'h1;
				brk_tail <= 1'b0;
			end else if (load_i && en_i) begin
				sh <= frame;
				cnt <= nbits;
				take_o <= 1'b1;
				is_char <= 1'b1;
			end else begin
				tx_o <= 1'b1;
			end
		end else if (tick_i) begin
			if (lead) begin
				lead <= 1'b0;
				tx_o <= sh[0];
			end else begin
				sub <= sub + 4'h1;
				if (sub == `SCI_SUB_LAST) begin
					sh <= {1'b1, sh[11:1]};
					tx_o <= sh[1];
					cnt <= cnt - 4'h1;
					done_o <= is_char && (cnt == 4'h1);
				end
			end
		end
		// a rising enable seen mid-frame queues a preamble behind it
		if (rise && cnt != 4'h0)
			pre <= 1'b1;
		// the pin stays driven through a frame or break tail in flight
		tx_oe_o <= en_i || (cnt != 4'h0) || brk_tail;
	end
end

endmodule // sci_tx
